// *** include/sdcc_pkg.sv ***
// package: command, stage and status codes for the stored-data clear interpreter
`default_nettype none
package sdcc_pkg;
  localparam int           POS_COUNT        = 64;
  localparam int           POS_ADDR_W       = 6;
  localparam int           PRM_COUNT        = 32;
  localparam int           PRM_ADDR_W       = 5;
  localparam int           IO_COUNT         = 16;
  localparam int           IO_ADDR_W        = 4;
  localparam int           SEQ_COUNT        = 16;
  localparam int           SEQ_ADDR_W       = 4;
  localparam int           LINE_W           = 8;
  localparam int           DATA_W           = 32;
  localparam int           STACK_DEPTH      = 4;
  localparam logic [7:0]   KEY_YES_UPPER    = 8'h59;
  localparam logic [7:0]   KEY_YES_LOWER    = 8'h79;
  localparam logic [31:0]  POS_CLEAR_VALUE  = 32'h0000_0000;
  localparam logic [31:0]  IO_UNASSIGNED    = 32'h0000_0000;

  typedef enum logic [1:0] {
    SDCC_CMD_NONE  = 2'h0,
    SDCC_CMD_ERASE = 2'h1,
    SDCC_CMD_ZERO  = 2'h2
  } sdcc_cmd_e;

  // which nonvolatile area a write lands in
  typedef enum logic [2:0] {
    SDCC_AREA_PRM = 3'h1,
    SDCC_AREA_POS = 3'h2,
    SDCC_AREA_SEQ = 3'h3,
    SDCC_AREA_IO  = 3'h4
  } sdcc_area_e;

  // status messages toward the terminal
  typedef enum logic [2:0] {
    SDCC_MSG_NONE     = 3'h0,
    SDCC_MSG_CONFIRM  = 3'h1,
    SDCC_MSG_PRM_OK   = 3'h2,
    SDCC_MSG_POS_OK   = 3'h3,
    SDCC_MSG_SEQ_OK   = 3'h4,
    SDCC_MSG_CANCEL   = 3'h5,
    SDCC_MSG_PROMPT   = 3'h6
  } sdcc_msg_e;

  typedef struct packed {
    logic        valid;
    sdcc_area_e  area;
    logic [7:0]  addr;
    logic [31:0] data;
  } sdcc_nvm_wr_s;

  typedef struct packed {
    logic [SEQ_ADDR_W-1:0] seq;
    logic [LINE_W-1:0]     line;
  } sdcc_pc_s;
endpackage : sdcc_pkg
`default_nettype wire

// *** rtl/sdcc_call_stack.sv ***
// call/return stack and line sequencer for stored sequences
`timescale 1ns/1ps
`default_nettype none
module sdcc_call_stack (
  input  wire logic              i_clock,
  input  wire logic              i_srst,
  input  wire logic              i_step,
  input  wire logic              i_call,
  input  wire logic [3:0]        i_call_target,
  input  wire logic              i_return,
  input  wire logic              i_wait_motion,
  input  wire logic              i_motion_busy,
  input  wire logic              i_start,
  input  wire logic [3:0]        i_start_seq,
  output sdcc_pkg::sdcc_pc_s     o_pc,
  output logic                   o_hold,
  output logic                   o_overflow
);
  typedef struct packed {
    sdcc_pkg::sdcc_pc_s [sdcc_pkg::STACK_DEPTH-1:0] stack;
    logic [2:0]                                     sp;
    sdcc_pkg::sdcc_pc_s                             pc;
    logic                                           ovf;
  } sdcc_cs_s;

  sdcc_cs_s st;
  sdcc_cs_s next_st;

  always_comb begin
    next_st = st;
    if (i_start) begin
      next_st.pc.seq  = i_start_seq;
      next_st.pc.line = '0;
      next_st.sp      = '0;
    end else if (i_step && !(i_wait_motion && i_motion_busy)) begin
      if (i_call) begin
        if (st.sp == 3'(sdcc_pkg::STACK_DEPTH)) begin
          next_st.ovf = 1'b1;
        end else begin
          // save the line after the call as the resume point
          next_st.stack[st.sp[1:0]].seq  = st.pc.seq;
          next_st.stack[st.sp[1:0]].line = st.pc.line + 8'h01;
          next_st.sp                     = st.sp + 3'h1;
          next_st.pc.seq                 = i_call_target;
          next_st.pc.line                = '0;
        end
      end else if (i_return && st.sp != 3'h0) begin
        next_st.pc = st.stack[st.sp[1:0] - 2'h1];
        next_st.sp = st.sp - 3'h1;
      end else begin
        next_st.pc.line = st.pc.line + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_pc       = st.pc;
  assign o_hold     = i_wait_motion & i_motion_busy;
  assign o_overflow = st.ovf;
endmodule : sdcc_call_stack
`default_nettype wire

// *** rtl/sdcc_clear_ctrl.sv ***
// clear-command interpreter: confirmation, staged nonvolatile wipes, sequence stepping
// How it works
// - erase-everything resets parameters, clears position table, deletes all sequences.
// - erase-everything also removes every input and output function assignment.
// - prompt first; only a Y or y key proceeds, any other key cancels untouched.
// - erased data is overwritten in place; no backup copy is kept.
// - zero-position-table writes 0 to every position entry, nothing else.
// - zeroed positions are overwritten; prior table contents are not retained.
// - subroutine return resumes at the line after the invoking call.
// - wait-motion-done holds the sequence until the index move completes.
// - call statement jumps to the numbered sequence as a subroutine.
`timescale 1ns/1ps
`default_nettype none
module sdcc_clear_ctrl (
  input  wire logic                  i_clock,
  input  wire logic                  i_srst,
  input  wire logic                  i_cmd_valid,
  input  wire sdcc_pkg::sdcc_cmd_e   i_cmd,
  output logic                       o_cmd_ready,
  input  wire logic                  i_key_valid,
  input  wire logic [7:0]            i_key,
  output logic                       o_msg_valid,
  output sdcc_pkg::sdcc_msg_e        o_msg,
  input  wire logic                  i_msg_ready,
  output sdcc_pkg::sdcc_nvm_wr_s     o_nvm_wr,
  input  wire logic                  i_nvm_ready,
  input  wire logic [31:0]           i_prm_default,
  output logic [4:0]                 o_prm_default_addr,
  input  wire logic                  i_seq_step,
  input  wire logic                  i_seq_call,
  input  wire logic [3:0]            i_seq_call_target,
  input  wire logic                  i_seq_return,
  input  wire logic                  i_seq_wait_motion,
  input  wire logic                  i_motion_busy,
  input  wire logic                  i_seq_start,
  input  wire logic [3:0]            i_seq_start_num,
  output sdcc_pkg::sdcc_pc_s         o_seq_pc,
  output logic                       o_seq_hold,
  output logic                       o_seq_overflow,
  output logic                       o_busy
);
  typedef enum logic [6:0] {
    SDCC_ST_IDLE    = 7'h01,
    SDCC_ST_PROMPT  = 7'h02,
    SDCC_ST_KEY     = 7'h04,
    SDCC_ST_PRM     = 7'h08,
    SDCC_ST_POS     = 7'h10,
    SDCC_ST_SEQ_IO  = 7'h20,
    SDCC_ST_REPORT  = 7'h40
  } sdcc_state_e;

  typedef struct packed {
    sdcc_state_e          state;
    sdcc_pkg::sdcc_cmd_e  cmd;
    logic [7:0]           idx;
    logic                 io_phase;
    sdcc_pkg::sdcc_msg_e  msg;
    logic                 msg_valid;
    logic                 msg_due;
    sdcc_state_e          after_msg;
    sdcc_pkg::sdcc_nvm_wr_s wr;
  } sdcc_ctl_s;

  sdcc_ctl_s st;
  sdcc_ctl_s next_st;

  // a write is only retired once the memory takes it
  function automatic logic wr_done(input sdcc_pkg::sdcc_nvm_wr_s w, input logic rdy);
    wr_done = !w.valid || rdy;
  endfunction : wr_done

  function automatic sdcc_pkg::sdcc_nvm_wr_s mk_wr(input sdcc_pkg::sdcc_area_e a,
                                                   input logic [7:0] ad, input logic [31:0] d);
    mk_wr.valid = 1'b1;
    mk_wr.area  = a;
    mk_wr.addr  = ad;
    mk_wr.data  = d;
  endfunction : mk_wr

  always_comb begin
    next_st = st;
    if (st.msg_valid && i_msg_ready) begin
      next_st.msg_valid = 1'b0;
    end
    if (st.wr.valid && i_nvm_ready) begin
      next_st.wr.valid = 1'b0;
    end
    case (st.state)
      SDCC_ST_IDLE: begin
        if (i_cmd_valid && i_cmd != sdcc_pkg::SDCC_CMD_NONE) begin
          next_st.cmd       = i_cmd;
          next_st.msg       = sdcc_pkg::SDCC_MSG_CONFIRM;
          next_st.msg_valid = 1'b1;
          next_st.state     = SDCC_ST_PROMPT;
        end
      end
      SDCC_ST_PROMPT: begin
        if (!st.msg_valid) begin
          next_st.state = SDCC_ST_KEY;
        end
      end
      SDCC_ST_KEY: begin
        if (i_key_valid) begin
          next_st.idx      = '0;
          next_st.io_phase = 1'b0;
          if (i_key == sdcc_pkg::KEY_YES_UPPER || i_key == sdcc_pkg::KEY_YES_LOWER) begin
            next_st.state = (st.cmd == sdcc_pkg::SDCC_CMD_ERASE) ? SDCC_ST_PRM : SDCC_ST_POS;
          end else begin
            next_st.msg       = sdcc_pkg::SDCC_MSG_CANCEL;
            next_st.msg_valid = 1'b1;
            next_st.after_msg = SDCC_ST_IDLE;
            next_st.state     = SDCC_ST_REPORT;
          end
        end
      end
      SDCC_ST_PRM: begin
        if (wr_done(st.wr, i_nvm_ready)) begin
          next_st.wr  = mk_wr(sdcc_pkg::SDCC_AREA_PRM, st.idx, i_prm_default);
          next_st.idx = st.idx + 8'h01;
          if (st.idx == 8'(sdcc_pkg::PRM_COUNT - 1)) begin
            next_st.idx       = '0;
            next_st.msg       = sdcc_pkg::SDCC_MSG_PRM_OK;
            next_st.msg_due   = 1'b1;
            next_st.after_msg = SDCC_ST_POS;
            next_st.state     = SDCC_ST_REPORT;
          end
        end
      end
      SDCC_ST_POS: begin
        if (wr_done(st.wr, i_nvm_ready)) begin
          // overwrite in place: old values are gone once written
          next_st.wr  = mk_wr(sdcc_pkg::SDCC_AREA_POS, st.idx, sdcc_pkg::POS_CLEAR_VALUE);
          next_st.idx = st.idx + 8'h01;
          if (st.idx == 8'(sdcc_pkg::POS_COUNT - 1)) begin
            next_st.idx       = '0;
            next_st.msg       = sdcc_pkg::SDCC_MSG_POS_OK;
            next_st.msg_due   = 1'b1;
            next_st.after_msg = (st.cmd == sdcc_pkg::SDCC_CMD_ERASE) ? SDCC_ST_SEQ_IO : SDCC_ST_IDLE;
            next_st.state     = SDCC_ST_REPORT;
          end
        end
      end
      SDCC_ST_SEQ_IO: begin
        if (wr_done(st.wr, i_nvm_ready)) begin
          next_st.idx = st.idx + 8'h01;
          if (!st.io_phase) begin
            next_st.wr = mk_wr(sdcc_pkg::SDCC_AREA_SEQ, st.idx, 32'h0000_0000);
            if (st.idx == 8'(sdcc_pkg::SEQ_COUNT - 1)) begin
              next_st.idx      = '0;
              next_st.io_phase = 1'b1;
            end
          end else begin
            next_st.wr = mk_wr(sdcc_pkg::SDCC_AREA_IO, st.idx, sdcc_pkg::IO_UNASSIGNED);
            if (st.idx == 8'(sdcc_pkg::IO_COUNT - 1)) begin
              next_st.idx       = '0;
              next_st.msg       = sdcc_pkg::SDCC_MSG_SEQ_OK;
              next_st.msg_due   = 1'b1;
              next_st.after_msg = SDCC_ST_IDLE;
              next_st.state     = SDCC_ST_REPORT;
            end
          end
        end
      end
      SDCC_ST_REPORT: begin
        // stage message waits for its last write, so it never runs ahead of memory
        if (st.msg_due) begin
          if (!next_st.wr.valid) begin
            next_st.msg_valid = 1'b1;
            next_st.msg_due   = 1'b0;
          end
        end else if (!next_st.msg_valid && !next_st.wr.valid) begin
          if (st.after_msg == SDCC_ST_IDLE && st.msg != sdcc_pkg::SDCC_MSG_PROMPT) begin
            next_st.msg       = sdcc_pkg::SDCC_MSG_PROMPT;
            next_st.msg_valid = 1'b1;
          end else begin
            next_st.state = st.after_msg;
          end
        end
      end
      default: begin
        next_st = '0;
        next_st.state = SDCC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st           <= '0;
      st.state     <= SDCC_ST_IDLE;
      st.after_msg <= SDCC_ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign o_cmd_ready        = (st.state == SDCC_ST_IDLE);
  assign o_msg_valid        = st.msg_valid;
  assign o_msg              = st.msg;
  assign o_nvm_wr           = st.wr;
  assign o_prm_default_addr = st.idx[4:0];
  assign o_busy             = (st.state != SDCC_ST_IDLE);

  sdcc_call_stack u_call_stack (
    .i_clock       (i_clock),
    .i_srst        (i_srst),
    .i_step        (i_seq_step),
    .i_call        (i_seq_call),
    .i_call_target (i_seq_call_target),
    .i_return      (i_seq_return),
    .i_wait_motion (i_seq_wait_motion),
    .i_motion_busy (i_motion_busy),
    .i_start       (i_seq_start),
    .i_start_seq   (i_seq_start_num),
    .o_pc          (o_seq_pc),
    .o_hold        (o_seq_hold),
    .o_overflow    (o_seq_overflow)
  );
endmodule : sdcc_clear_ctrl
`default_nettype wire

// *** verif/sdcc_clear_ctrl_sva.sv ***
// checker for the clear-command interpreter ports
`timescale 1ns/1ps
`default_nettype none
module sdcc_clear_ctrl_sva (
  input wire logic                   i_clock,
  input wire logic                   i_srst,
  input wire logic                   i_cmd_valid,
  input wire sdcc_pkg::sdcc_cmd_e    i_cmd,
  input wire logic                   o_cmd_ready,
  input wire logic                   o_msg_valid,
  input wire sdcc_pkg::sdcc_msg_e    o_msg,
  input wire logic                   i_msg_ready,
  input wire sdcc_pkg::sdcc_nvm_wr_s o_nvm_wr,
  input wire logic                   i_nvm_ready,
  input wire logic                   i_seq_step,
  input wire logic                   i_seq_call,
  input wire logic                   o_seq_hold,
  input wire sdcc_pkg::sdcc_pc_s     o_seq_pc,
  input wire logic                   o_seq_overflow
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  cmd_confirm_a: assert property (
    o_cmd_ready && i_cmd_valid && i_cmd != sdcc_pkg::SDCC_CMD_NONE |=>
    o_msg_valid && o_msg == sdcc_pkg::SDCC_MSG_CONFIRM) else $error("no confirm");
  idle_quiet_a: assert property (o_cmd_ready |-> !o_nvm_wr.valid) else $error("idle write");
  msg_hold_a: assert property (o_msg_valid && !i_msg_ready |=> o_msg_valid && $stable(o_msg))
    else $error("msg dropped");
  wr_hold_a: assert property (o_nvm_wr.valid && !i_nvm_ready |=> $stable(o_nvm_wr))
    else $error("write dropped");
  pos_zero_a: assert property (
    o_nvm_wr.valid && o_nvm_wr.area == sdcc_pkg::SDCC_AREA_POS |->
    o_nvm_wr.data == sdcc_pkg::POS_CLEAR_VALUE) else $error("pos not zero");
  io_clear_a: assert property (
    o_nvm_wr.valid && o_nvm_wr.area == sdcc_pkg::SDCC_AREA_IO |->
    o_nvm_wr.data == sdcc_pkg::IO_UNASSIGNED) else $error("io kept");
  prompt_after_a: assert property (
    o_msg_valid && i_msg_ready && o_msg inside {sdcc_pkg::SDCC_MSG_CANCEL, sdcc_pkg::SDCC_MSG_SEQ_OK}
    |-> ##[1:4] (o_msg_valid && o_msg == sdcc_pkg::SDCC_MSG_PROMPT)) else $error("no prompt");
  hold_step_a: assert property (i_seq_step && o_seq_hold |=> $stable(o_seq_pc))
    else $error("stepped in wait");
  call_jump_a: assert property (
    i_seq_step && i_seq_call && !o_seq_hold && !o_seq_overflow |=>
    o_seq_pc.line == 8'h00 || o_seq_overflow) else $error("call no jump");
  cover property (o_nvm_wr.valid && o_nvm_wr.area == sdcc_pkg::SDCC_AREA_IO);
  cover property (o_msg_valid && o_msg == sdcc_pkg::SDCC_MSG_CANCEL);
  cover property (i_seq_step && o_seq_hold);
endmodule : sdcc_clear_ctrl_sva
bind sdcc_clear_ctrl sdcc_clear_ctrl_sva chk_u (
  .i_clock        (i_clock),
  .i_srst         (i_srst),
  .i_cmd_valid    (i_cmd_valid),
  .i_cmd          (i_cmd),
  .o_cmd_ready    (o_cmd_ready),
  .o_msg_valid    (o_msg_valid),
  .o_msg          (o_msg),
  .i_msg_ready    (i_msg_ready),
  .o_nvm_wr       (o_nvm_wr),
  .i_nvm_ready    (i_nvm_ready),
  .i_seq_step     (i_seq_step),
  .i_seq_call     (i_seq_call),
  .o_seq_hold     (o_seq_hold),
  .o_seq_pc       (o_seq_pc),
  .o_seq_overflow (o_seq_overflow)
);
`default_nettype wire

// *** verif/sdcc_term_model.sv ***
// terminal and memory partner with irregular acceptance
`timescale 1ns/1ps
`default_nettype none
module sdcc_term_model #(parameter logic [31:0] DEF_BASE = 32'hD000_0000) (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic [4:0]  i_prm_addr,
  output logic             o_msg_ready,
  output logic             o_nvm_ready,
  output logic [31:0]      o_prm_default
);
  logic [3:0] cnt;
  always_ff @(posedge i_clock) cnt <= i_srst ? 4'h0 : cnt + 4'h1;
  // stalls on both sides so held outputs get exercised
  assign o_msg_ready = cnt[1] | cnt[3];
  assign o_nvm_ready = cnt[0] | cnt[2];
  assign o_prm_default = DEF_BASE | {27'h0, i_prm_addr};
endmodule : sdcc_term_model
`default_nettype wire

// *** verif/sdcc_clear_ctrl_tb.sv ***
// self-checking bench for the clear-command interpreter
`timescale 1ns/1ps
`default_nettype none
module sdcc_clear_ctrl_tb;
  localparam logic [31:0] DEF_BASE = 32'hD000_0000;
  logic i_clock = 1'b0, i_srst = 1'b1, i_cmd_valid = 1'b0, i_key_valid = 1'b0, i_seq_step = 1'b0;
  logic i_seq_call = 1'b0, i_seq_return = 1'b0, i_seq_wait_motion = 1'b0, i_motion_busy = 1'b0;
  logic i_seq_start = 1'b0, o_cmd_ready, o_msg_valid, i_msg_ready, i_nvm_ready, o_seq_hold;
  logic o_seq_overflow, o_busy;
  logic [7:0] i_key = 8'h00;
  logic [3:0] i_seq_call_target = 4'h0, i_seq_start_num = 4'h0, s, t;
  logic [31:0] i_prm_default, rng = 32'hA000;
  logic [4:0] o_prm_default_addr;
  sdcc_pkg::sdcc_cmd_e i_cmd = sdcc_pkg::SDCC_CMD_NONE;
  sdcc_pkg::sdcc_msg_e o_msg;
  sdcc_pkg::sdcc_nvm_wr_s o_nvm_wr;
  sdcc_pkg::sdcc_pc_s o_seq_pc;
  logic [43:0] exp_q[$];
  int n_mismatch = 0, cmp_count = 0;
  always #50 i_clock = ~i_clock;
  sdcc_clear_ctrl dut_u (.i_clock, .i_srst, .i_cmd_valid, .i_cmd, .o_cmd_ready, .i_key_valid, .i_key,
    .o_msg_valid, .o_msg, .i_msg_ready, .o_nvm_wr, .i_nvm_ready, .i_prm_default, .o_prm_default_addr,
    .i_seq_step, .i_seq_call, .i_seq_call_target, .i_seq_return, .i_seq_wait_motion, .i_motion_busy,
    .i_seq_start, .i_seq_start_num, .o_seq_pc, .o_seq_hold, .o_seq_overflow, .o_busy);
  sdcc_term_model #(.DEF_BASE(DEF_BASE)) term_u (.i_clock, .i_srst, .i_prm_addr(o_prm_default_addr),
    .o_msg_ready(i_msg_ready), .o_nvm_ready(i_nvm_ready), .o_prm_default(i_prm_default));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic pop(input logic [43:0] got);
    if (exp_q.size() == 0) chk(got, 44'hFFF_FFFF_FFFF);
    else chk(got, exp_q.pop_front());
  endtask : pop
  always @(posedge i_clock) begin
    if (!i_srst && o_msg_valid && i_msg_ready) pop({1'b1, 40'h0, o_msg});
    if (!i_srst && o_nvm_wr.valid && i_nvm_ready) pop({1'b0, o_nvm_wr.area, o_nvm_wr.addr, o_nvm_wr.data});
  end
  task automatic push_msg(input sdcc_pkg::sdcc_msg_e m);
    exp_q.push_back({1'b1, 40'h0, m});
  endtask : push_msg
  // pos, seq and io words all clear to zero
  task automatic push_area(input sdcc_pkg::sdcc_area_e a, input int n);
    for (int k = 0; k < n; k++)
      exp_q.push_back({1'b0, a, 8'(k), a == sdcc_pkg::SDCC_AREA_PRM ? DEF_BASE | 32'(k) : 32'h0});
  endtask : push_area
  task automatic run_cmd(input sdcc_pkg::sdcc_cmd_e c, input logic [7:0] k);
    int i;
    logic go;
    logic er;
    go = (k | 8'h20) == sdcc_pkg::KEY_YES_LOWER;
    er = c == sdcc_pkg::SDCC_CMD_ERASE;
    push_msg(sdcc_pkg::SDCC_MSG_CONFIRM);
    if (!go) push_msg(sdcc_pkg::SDCC_MSG_CANCEL);
    if (go && er) push_area(sdcc_pkg::SDCC_AREA_PRM, sdcc_pkg::PRM_COUNT);
    if (go && er) push_msg(sdcc_pkg::SDCC_MSG_PRM_OK);
    if (go) push_area(sdcc_pkg::SDCC_AREA_POS, sdcc_pkg::POS_COUNT);
    if (go) push_msg(sdcc_pkg::SDCC_MSG_POS_OK);
    if (go && er) push_area(sdcc_pkg::SDCC_AREA_SEQ, sdcc_pkg::SEQ_COUNT);
    if (go && er) push_area(sdcc_pkg::SDCC_AREA_IO, sdcc_pkg::IO_COUNT);
    if (go && er) push_msg(sdcc_pkg::SDCC_MSG_SEQ_OK);
    push_msg(sdcc_pkg::SDCC_MSG_PROMPT);
    @(posedge i_clock);
    i_cmd_valid <= 1'b1;
    i_cmd <= c;
    @(posedge i_clock);
    i_cmd_valid <= 1'b0;
    for (i = 0; i < 50; i++) begin
      @(posedge i_clock);
      if (o_msg_valid && i_msg_ready) break;
    end
    if (i == 50) begin
      n_mismatch++;
      end_sim();
    end
    repeat (2) @(posedge i_clock);
    i_key_valid <= 1'b1;
    i_key <= k;
    @(posedge i_clock);
    i_key_valid <= 1'b0;
    for (i = 0; i < 3000; i++) begin
      @(posedge i_clock);
      if (o_cmd_ready === 1'b1 && exp_q.size() == 0) break;
    end
    if (i == 3000) begin
      n_mismatch++;
      end_sim();
    end
    chk({43'h0, o_busy}, 44'h0);
  endtask : run_cmd
  task automatic seq_op(input logic st, input logic c, input logic r, input logic w, input logic b);
    @(posedge i_clock);
    i_seq_start <= st;
    i_seq_start_num <= s;
    i_seq_step <= !st;
    i_seq_call <= c;
    i_seq_call_target <= t;
    i_seq_return <= r;
    i_seq_wait_motion <= w;
    i_motion_busy <= b;
    @(posedge i_clock);
    i_seq_start <= 1'b0;
    i_seq_step <= 1'b0;
    #1;
  endtask : seq_op
  initial begin
    repeat (8) @(posedge i_clock);
    i_srst <= 1'b0;
    // zero and erase run once each; the cancel case then loops over both commands
    run_cmd(sdcc_pkg::SDCC_CMD_ZERO, sdcc_pkg::KEY_YES_UPPER);
    $display("test zero_table done");
    run_cmd(sdcc_pkg::SDCC_CMD_ERASE, sdcc_pkg::KEY_YES_LOWER);
    $display("test erase_all done");
    for (int j = 1; j < 3; j++) begin
      rng = xs(rng);
      run_cmd(sdcc_pkg::sdcc_cmd_e'(j), (rng[7:0] | 8'h20) == 8'h79 ? 8'h1B : rng[7:0]);
    end
    $display("test cancel done");
    rng = xs(rng);
    s = rng[3:0];
    t = rng[7:4];
    seq_op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({32'h0, o_seq_pc}, {32'h0, s, 8'h00});
    seq_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    seq_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    seq_op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    chk({32'h0, o_seq_pc}, {32'h0, t, 8'h00});
    seq_op(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    chk({32'h0, o_seq_pc}, {32'h0, t, 8'h00});
    chk({43'h0, o_seq_hold}, 44'h1);
    seq_op(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    chk({32'h0, o_seq_pc}, {32'h0, t, 8'h01});
    seq_op(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    chk({32'h0, o_seq_pc}, {32'h0, s, 8'h03});
    chk({43'h0, o_seq_overflow}, 44'h0);
    $display("test sequence done");
    end_sim();
  end
endmodule : sdcc_clear_ctrl_tb
`default_nettype wire
